// ### core/spi_link_pkg.sv
// Constants, frame layout and check-code function shared by both link ends
//
// Behaviour
// - Check code polynomial x^5+x^4+x^2+1 in checked modes
// - Code over 19 bits plus seed 00111
// - Bad code sets frame error, drives fault
// - Frame error clears on next clean frame
// - Commands in bad frames have no effect
// - Select fall captures inputs, enables port
// - Sample on rising, shift on falling edge
// - Read/write indicator first, MSB first
// - Clock edges ignored while deselected
// - Host idles clock low: mode 0
// - First byte out is captured inputs 8..1
// - Direct write: second byte all zeros
// - Direct read: register in same frame
// - Chain strap low direct, high chain
// - Check strap high: 16 bits, unchecked
// - Chain mode decodes after select rises
// - Chain read answered in following frame
// - Non-multiple-of-8 clock count: discard, flag
// - Snapshot pin captures inputs across devices
// - Chain wiring: data passes device to device
// - Frame fields: rw, address, data, fill, code
package spi_link_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Frame layout
    localparam int FRAME_LONG = 24;
    localparam int FRAME_SHORT = 16;
    localparam int CRC_W = 5;
    localparam int CRC_DATA_BITS = 19;
    localparam int ADDR_W = 7;
    localparam int BYTE_W = 8;
    localparam int BITCNT_W = 16;
    localparam logic [5:0] CRC_POLY = 6'h35;
    localparam logic [4:0] CRC_SEED = 5'h07;

    ////////////////////////////////////////////////////////////////////////
    // Host register map and fields
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [3:0] TX_PAGE = 4'h1;
    localparam logic [3:0] RX_PAGE = 4'h2;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CRC_BIT = 1;
    localparam int CTRL_CNT_LSB = 4;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_HALF_NS = 40;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Long division of {data, seed}; remainder is the code
    function automatic logic [4:0] crc5(input logic [18:0] d);
        logic [23:0] m;
        m = {d, CRC_SEED};
        for (int i = 23; i >= 5; i--)
        begin
            if (m[i])
                m[i -: 6] = m[i -: 6] ^ CRC_POLY;
        end
        return m[4:0];
    endfunction

endpackage

// ### core/spi_link_if.sv
// Four-wire serial link between host and target
`timescale 1ns/1ps
interface spi_link_if;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo;
    logic sdo_oe_n;

    modport host (output sclk, output cs_n, output sdi, input sdo);
    modport target (input sclk, input cs_n, input sdi, output sdo, output sdo_oe_n);
endinterface

// ### core/pin_sync.sv
// Two-flop synchroniser for a vector of unrelated levels
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input logic clk,
    input logic rst_n,
    // Levels
    input logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ### core/spi_target.sv
// Target end: input serializer port with check code and chaining
`timescale 1ns/1ps
module spi_target (
    // Clock and reset
    input logic hclk,
    input logic hresetn,
    // Link
    spi_link_if.target link,
    // Straps, snapshot and field side
    input logic crc_disable_strap,
    input logic chain_select_strap,
    input logic latch_n,
    input logic [7:0] field_input_states,
    input logic field_supply_low_flag,
    input logic field_supply_missing_flag,
    // Register file side
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    // Fault side
    input logic frame_check_error_enable,
    input logic bit_count_error_clear,
    output logic frame_check_error_flag,
    output logic bit_count_error_flag,
    output logic fault_active
);
    logic [15:0] sync_q;
    logic latch_q, sdi_q, cs_q, sclk_q, crcdis_q, chain_q, vlow_q, vmiss_q;
    logic [7:0] field_q;
    logic sclk_d_r, cs_d_r, latch_d_r;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, snap_fall;
    logic crc_mode_r, chain_r;
    logic [spi_link_pkg::BITCNT_W-1:0] cnt_r;
    logic [23:0] rx_r, tx_r;
    logic [7:0] fld_r, snap_r, pend_r;
    logic [1:0] flags_r;
    logic snap_v_r, load2_r, load3_r, read_pend_r;
    logic reg_wr_r, reg_rd_r, fce_r, bce_r, fault_r;
    logic [6:0] reg_addr_r;
    logic [7:0] reg_wdata_r;
    logic [23:0] frm;
    logic [7:0] flen, cap_fld, byte2;
    logic crc_good, mult8, long_enough, exec;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; select and snapshot rest high
    pin_sync #(.W(16), .RST_VAL(16'hA000)) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d({latch_n, link.sdi, link.cs_n, link.sclk, crc_disable_strap, chain_select_strap,
            field_supply_low_flag, field_supply_missing_flag, field_input_states}),
        .q(sync_q)
    );
    assign {latch_q, sdi_q, cs_q, sclk_q, crcdis_q, chain_q, vlow_q, vmiss_q, field_q} = sync_q;

    // Edge detect on the synchronised copies
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            latch_d_r <= 1'b1;
        end
        else
        begin
            sclk_d_r <= sclk_q;
            cs_d_r <= cs_q;
            latch_d_r <= latch_q;
        end
    end
    assign sclk_rise = sclk_q & ~sclk_d_r & ~cs_q;
    assign sclk_fall = ~sclk_q & sclk_d_r & ~cs_q;
    assign cs_fall = ~cs_q & cs_d_r;
    assign cs_rise = cs_q & ~cs_d_r;
    assign snap_fall = ~latch_q & latch_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Frame decode terms
    always_comb
    begin
        flen = crc_mode_r ? 8'(spi_link_pkg::FRAME_LONG) : 8'(spi_link_pkg::FRAME_SHORT);
        frm = crc_mode_r ? rx_r : {rx_r[15:0], 8'h00};
        crc_good = spi_link_pkg::crc5(frm[23:5]) == frm[4:0];
        mult8 = cnt_r[2:0] == 3'h0;
        long_enough = (cnt_r != '0) && (cnt_r >= spi_link_pkg::BITCNT_W'(flen));
        exec = cs_rise && mult8 && long_enough && (!crc_mode_r || crc_good);
        cap_fld = snap_v_r ? snap_r : field_q;
        byte2 = chain_q ? pend_r : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Straps are taken per frame, at select fall
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            crc_mode_r <= 1'b1;
            chain_r <= 1'b0;
            fld_r <= 8'h00;
            flags_r <= 2'h0;
        end
        else if (cs_fall)
        begin
            crc_mode_r <= ~crcdis_q;
            chain_r <= chain_q;
            fld_r <= cap_fld;
            flags_r <= {vlow_q, vmiss_q};
        end
    end

    // Snapshot held until the next frame consumes it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            snap_r <= 8'h00;
            snap_v_r <= 1'b0;
        end
        else if (snap_fall)
        begin
            snap_r <= field_q;
            snap_v_r <= 1'b1;
        end
        else if (cs_fall)
            snap_v_r <= 1'b0;
    end

    // Clock pulse count; wraps at a multiple of 8 so the test survives
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_r <= '0;
        else if (cs_fall)
            cnt_r <= '0;
        else if (sclk_rise)
            cnt_r <= cnt_r + 1'b1;
    end

    // Receive shifter, rising edges only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rx_r <= 24'h000000;
        else if (sclk_rise)
            rx_r <= {rx_r[22:0], sdi_q};
    end

    ////////////////////////////////////////////////////////////////////////
    // Direct read: address known after 8 bits, data patched in before bit 8 leaves
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            load2_r <= 1'b0;
            load3_r <= 1'b0;
        end
        else
        begin
            load2_r <= sclk_rise && (cnt_r == 16'h0007) && !chain_r;
            load3_r <= load2_r && !rx_r[7];
        end
    end

    // Transmit shifter doubles as the one-frame delay line in chain mode
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tx_r <= 24'h000000;
        else if (cs_fall)
        begin
            if (!crcdis_q)
                tx_r <= {cap_fld, byte2, vlow_q, vmiss_q, 1'b0,
                         spi_link_pkg::crc5({cap_fld, byte2, vlow_q, vmiss_q, 1'b0})};
            else
                tx_r <= {cap_fld, byte2, 8'h00};
        end
        else if (load3_r)
        begin
            // Seven shifts done: byte 2 now at 22:15, code at 11:7
            tx_r[22:15] <= reg_rdata;
            tx_r[11:7] <= spi_link_pkg::crc5({fld_r, reg_rdata, flags_r, 1'b0});
        end
        else if (sclk_fall)
            tx_r <= crc_mode_r ? {tx_r[22:0], rx_r[0]} : {tx_r[22:8], rx_r[0], 8'h00};
    end
    assign link.sdo = tx_r[23];
    assign link.sdo_oe_n = cs_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Command execution at select rise
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            reg_wr_r <= 1'b0;
            reg_rd_r <= 1'b0;
            reg_addr_r <= 7'h00;
            reg_wdata_r <= 8'h00;
        end
        else
        begin
            reg_wr_r <= exec && frm[23];
            reg_rd_r <= exec && !frm[23];
            if (exec)
                reg_addr_r <= frm[22:16];
            else if (load2_r && !rx_r[7])
                reg_addr_r <= rx_r[6:0];
            if (exec && frm[23])
                reg_wdata_r <= frm[15:8];
        end
    end

    // Chain read data waits for the next frame; anything else leaves zeros
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_r <= 8'h00;
            read_pend_r <= 1'b0;
        end
        else
        begin
            read_pend_r <= exec && !frm[23] && chain_r;
            if (read_pend_r)
                pend_r <= reg_rdata;
            else if (cs_rise)
                pend_r <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault flags; the frame error follows each checked frame, never latched
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fce_r <= 1'b0;
            bce_r <= 1'b0;
            fault_r <= 1'b0;
        end
        else
        begin
            if (cs_rise && mult8 && long_enough && crc_mode_r)
                fce_r <= !crc_good;
            if (cs_rise && !mult8)
                bce_r <= 1'b1;
            else if (bit_count_error_clear)
                bce_r <= 1'b0;
            fault_r <= fce_r && frame_check_error_enable;
        end
    end

    assign reg_wr = reg_wr_r;
    assign reg_rd = reg_rd_r;
    assign reg_addr = reg_addr_r;
    assign reg_wdata = reg_wdata_r;
    assign frame_check_error_flag = fce_r;
    assign bit_count_error_flag = bce_r;
    assign fault_active = fault_r;
endmodule

// ### core/spi_host.sv
// Host end: AHB-Lite programmed frame engine driving the link
`timescale 1ns/1ps
module spi_host #(
    parameter int MAX_FRAMES = 4,
    parameter int HALF_CYC = spi_link_pkg::SCLK_HALF_CYC
) (
    // Clock and reset
    input logic hclk,
    input logic hresetn,
    // AHB-Lite slave
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Link
    spi_link_if.host link
);
    typedef enum {IDLE, LOWP, HIGHP, TAIL, GAP} hst_t;

    if (MAX_FRAMES < 1 || MAX_FRAMES > 4 || HALF_CYC < 2 || HALF_CYC > 255)
    begin : g_chk
        $error("spi_host: unsupported parameters");
    end

    logic [15:0] tx_mem [MAX_FRAMES];
    logic [23:0] rx_mem [MAX_FRAMES];
    logic [2:0] ctrl_r;
    logic busy_r, done_r, start;
    logic ap_v_r, ap_wr_r;
    logic [7:0] ap_a_r;
    logic [31:0] hrdata_r, rd_val;
    logic hready_r;
    hst_t st_r;
    logic [7:0] ph_r;
    logic [4:0] bi_r;
    logic [1:0] fi_r;
    logic [23:0] sh_r, rsh_r;
    logic sclk_r, cs_n_r, mosi_r, miso_q;
    logic [4:0] flen;
    logic [3:0] crc_ok;

    // Host frame: rw, address, data, then fill and check code
    function automatic logic [23:0] build(input logic [15:0] w, input logic chk);
        return chk ? {w, 3'h0, spi_link_pkg::crc5({w, 3'h0})} : {w, 8'h00};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // AHB address phase; reads take one wait state so a write just ahead lands first
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_v_r <= 1'b0;
            ap_wr_r <= 1'b0;
            ap_a_r <= 8'h00;
            hready_r <= 1'b1;
            hrdata_r <= 32'h00000000;
        end
        else
        begin
            if (hready)
            begin
                ap_v_r <= hsel && htrans[1];
                ap_wr_r <= hwrite;
                ap_a_r <= haddr[7:0];
                hready_r <= !(hsel && htrans[1] && !hwrite);
            end
            else
                hready_r <= 1'b1;
            if (ap_v_r && !ap_wr_r)
                hrdata_r <= rd_val;
        end
    end
    assign hrdata = hrdata_r;
    assign hreadyout = hready_r;
    assign hresp = 1'b0;

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            crc_ok[i] = (i < MAX_FRAMES) ? (spi_link_pkg::crc5(rx_mem[i][23:5]) == rx_mem[i][4:0]) : 1'b0;
        rd_val = 32'h00000000;
        if (ap_a_r == spi_link_pkg::CTRL_OFS)
            rd_val = {26'h0, ctrl_r[2:1], 2'h0, ctrl_r[0], 1'b0};
        else if (ap_a_r == spi_link_pkg::STAT_OFS)
            rd_val = {20'h0, crc_ok, 6'h0, done_r, busy_r};
        else if (ap_a_r[7:4] == spi_link_pkg::TX_PAGE && 32'(ap_a_r[3:2]) < MAX_FRAMES)
            rd_val = {16'h0, tx_mem[ap_a_r[3:2]]};
        else if (ap_a_r[7:4] == spi_link_pkg::RX_PAGE && 32'(ap_a_r[3:2]) < MAX_FRAMES)
            rd_val = {8'h0, rx_mem[ap_a_r[3:2]]};
    end

    assign start = ap_v_r && ap_wr_r && ap_a_r == spi_link_pkg::CTRL_OFS
                   && hwdata[spi_link_pkg::CTRL_START_BIT] && !busy_r;

    // Control and transmit words; control is frozen while busy
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_r <= spi_link_pkg::CTRL_RESET;
            for (int i = 0; i < MAX_FRAMES; i++)
                tx_mem[i] <= 16'h0000;
        end
        else if (ap_v_r && ap_wr_r && !busy_r)
        begin
            if (ap_a_r == spi_link_pkg::CTRL_OFS)
                ctrl_r <= {hwdata[spi_link_pkg::CTRL_CNT_LSB +: 2], hwdata[spi_link_pkg::CTRL_CRC_BIT]};
            else if (ap_a_r[7:4] == spi_link_pkg::TX_PAGE && 32'(ap_a_r[3:2]) < MAX_FRAMES)
                tx_mem[ap_a_r[3:2]] <= hwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Returning data passes two flops before use
    pin_sync #(.W(1), .RST_VAL(1'b0)) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d(link.sdo),
        .q(miso_q)
    );

    assign flen = ctrl_r[0] ? 5'(spi_link_pkg::FRAME_LONG) : 5'(spi_link_pkg::FRAME_SHORT);

    // Frame engine: mode 0, clock idles low, frames back to back under one select
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= IDLE;
            ph_r <= 8'h00;
            bi_r <= 5'h00;
            fi_r <= 2'h0;
            sh_r <= 24'h000000;
            rsh_r <= 24'h000000;
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            mosi_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            for (int i = 0; i < MAX_FRAMES; i++)
                rx_mem[i] <= 24'h000000;
        end
        else
        begin
            ph_r <= ph_r + 1'b1;
            case (st_r)
                IDLE:
                begin
                    sclk_r <= 1'b0;
                    if (start)
                    begin
                        sh_r <= build(tx_mem[0], hwdata[spi_link_pkg::CTRL_CRC_BIT]);
                        mosi_r <= tx_mem[0][15];
                        cs_n_r <= 1'b0;
                        busy_r <= 1'b1;
                        done_r <= 1'b0;
                        fi_r <= 2'h0;
                        bi_r <= 5'h00;
                        ph_r <= 8'h00;
                        st_r <= LOWP;
                    end
                end
                LOWP:
                    if (ph_r == 8'(HALF_CYC - 1))
                    begin
                        sclk_r <= 1'b1;
                        ph_r <= 8'h00;
                        st_r <= HIGHP;
                    end
                HIGHP:
                    if (ph_r == 8'(HALF_CYC - 1))
                    begin
                        // Sample late in the high phase, then drop the clock and shift
                        sclk_r <= 1'b0;
                        ph_r <= 8'h00;
                        rsh_r <= {rsh_r[22:0], miso_q};
                        st_r <= LOWP;
                        if (bi_r == flen - 1'b1)
                        begin
                            rx_mem[fi_r] <= ctrl_r[0] ? {rsh_r[22:0], miso_q} : {rsh_r[14:0], miso_q, 8'h00};
                            bi_r <= 5'h00;
                            if (fi_r == ctrl_r[2:1] || 32'(fi_r) == MAX_FRAMES - 1)
                                st_r <= TAIL;
                            else
                            begin
                                fi_r <= fi_r + 1'b1;
                                sh_r <= build(tx_mem[fi_r + 1'b1], ctrl_r[0]);
                                mosi_r <= tx_mem[fi_r + 1'b1][15];
                            end
                        end
                        else
                        begin
                            bi_r <= bi_r + 1'b1;
                            sh_r <= {sh_r[22:0], 1'b0};
                            mosi_r <= sh_r[22];
                        end
                    end
                TAIL:
                    if (ph_r == 8'(HALF_CYC - 1))
                    begin
                        cs_n_r <= 1'b1;
                        ph_r <= 8'h00;
                        st_r <= GAP;
                    end
                GAP:
                    // Gives the targets time to decode before the next select
                    if (ph_r == 8'(2 * HALF_CYC - 1))
                    begin
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                        st_r <= IDLE;
                    end
                default:
                    st_r <= IDLE;
            endcase
        end
    end
    assign link.sclk = sclk_r;
    assign link.cs_n = cs_n_r;
    assign link.sdi = mosi_r;
endmodule

// ### verification/spi_link_checker.sv
// Concurrent checks on the serial link wires between host and target
`timescale 1ns/1ps
module spi_link_checker (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link wires
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic [6:0] rise_cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // Clock rises inside one select window; cleared while deselected
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rise_cnt_r <= 7'h00;
        else if (cs_n)
            rise_cnt_r <= 7'h00;
        else if ($rose(sclk))
            rise_cnt_r <= rise_cnt_r + 7'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Wire rules; high phase is exactly four system cycles at the default
    idle_clock_low_a: assert property (cs_n |-> !sclk)
        else $error("link clock high while deselected");
    select_clock_low_a: assert property ($fell(cs_n) |-> !sclk && !$past(sclk))
        else $error("select fell with link clock high");
    sdo_hold_high_a: assert property (!cs_n && sclk && $past(sclk) |-> $stable(sdo))
        else $error("target data moved during clock high");
    sdi_hold_high_a: assert property (!cs_n && sclk && $past(sclk) |-> $stable(sdi))
        else $error("host data moved during clock high");
    whole_bytes_a: assert property ($rose(cs_n) |-> rise_cnt_r[2:0] == 3'h0 && rise_cnt_r != 7'h00)
        else $error("frame not a whole number of bytes");
    release_after_frame_a: assert property ($rose(cs_n) |-> ##[0:5] sdo_oe_n)
        else $error("target kept driving after select rose");
    drive_when_selected_a: assert property ($fell(cs_n) |-> ##[0:5] !sdo_oe_n)
        else $error("target did not drive after select fell");
    high_phase_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("link clock high phase of wrong length");
    off_while_idle_a: assert property (cs_n [*8] |-> sdo_oe_n)
        else $error("target driving while idle");

    // Main scenarios reached
    cover property ($rose(cs_n));
    cover property (!sdo_oe_n && sdo);
    cover property ($fell(cs_n) ##[1:8] $rose(sclk));
endmodule

// ### verification/spi_target_crc_daisy_chain_test.sv
// Bench: AHB-Lite driven host talking to one target over the link
`timescale 1ns/1ps
module spi_target_crc_daisy_chain_test;
    logic hclk;
    logic hresetn;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic crc_disable_strap;
    logic chain_select_strap;
    logic latch_n;
    logic [7:0] field_input_states;
    logic reg_wr;
    logic reg_rd;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic fce_en;
    logic fce_flag;
    logic bce_flag;
    logic fault;
    logic code_ok;
    logic [14:0] last_wr;
    logic [6:0] last_rd;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_wr = 0;
    int cyc = 0;

    spi_link_if link ();
    spi_host spi_host_inst (.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .link(link.host));
    spi_target spi_target_inst (.hclk, .hresetn, .link(link.target), .crc_disable_strap,
        .chain_select_strap, .latch_n, .field_input_states, .field_supply_low_flag(1'h1),
        .field_supply_missing_flag(1'h0), .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .frame_check_error_enable(fce_en), .bit_count_error_clear(1'h0),
        .frame_check_error_flag(fce_flag), .bit_count_error_flag(bce_flag), .fault_active(fault));
    spi_link_checker spi_link_checker_inst (.hclk, .hresetn, .sclk(link.sclk), .cs_n(link.cs_n),
        .sdi(link.sdi), .sdo(link.sdo), .sdo_oe_n(link.sdo_oe_n));

    ////////////////////////////////////////////////////////////////////////
    // Register file stand-in: data marks the address so reads are traceable
    assign reg_rdata = {1'h1, reg_addr};

    // Clock, and a ceiling that cuts a hang short
    initial
    begin
        hclk = 1'h0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk)
    begin
        cyc++;
        if (reg_wr === 1'h1) n_wr++;
        if (reg_wr === 1'h1) last_wr = {reg_addr, reg_wdata};
        if (reg_rd === 1'h1) last_rd = reg_addr;
        if (cyc == 40000) n_mismatch++;
        if (cyc == 40000) wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One single transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        rd = hrdata;
    endtask

    // Send frames from TX0 on, as many as ctl sets, wait for done, fetch RX0
    task automatic frame(input logic [15:0] tx, input logic [31:0] ctl, output logic [31:0] rx);
        logic [31:0] st;
        bus(1'h1, 32'h10, {16'h0, tx}, st);
        bus(1'h1, 32'h00, ctl, st);
        st = 32'h1;
        while (st[0] !== 1'h0 || st[1] !== 1'h1) bus(1'h0, 32'h04, 32'h0, st);
        code_ok = st[8];
        bus(1'h0, 32'h20, 32'h0, rx);
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    // Two short frames land as one checked frame with a wrong code
    task automatic t_bad_code();
        logic [31:0] rx;
        bus(1'h1, 32'h14, 32'h0, rx);
        frame(16'h95A5, 32'h11, rx);
        check(n_wr, 0);
        check({fce_flag, fault, bce_flag}, 3'h6);
    endtask

    task automatic t_direct_write();
        logic [31:0] rx;
        frame({1'h1, 7'h15, 8'hA5}, 32'h3, rx);
        check(rx[23:8], {8'h5C, 8'h00});
        check(rx[7:5], 3'h4);
        check(code_ok, 1'h1);
        check(last_wr, {7'h15, 8'hA5});
        frame({1'h0, 7'h15, 8'h00}, 32'h3, rx);
        check({rx[23:5], code_ok}, {16'h5C95, 3'h4, 1'h1});
        check({fce_flag, fault}, 2'h0);
    endtask

    task automatic t_direct_read();
        logic [31:0] rx;
        int w0;
        @(posedge hclk);
        crc_disable_strap <= 1'h1;
        w0 = n_wr;
        frame({1'h0, 7'h2A, 8'h00}, 32'h1, rx);
        check(rx[23:0], {8'h5C, 8'hAA, 8'h00});
        check(last_rd, 7'h2A);
        check(n_wr - w0, 0);
    endtask

    // Chain read answered next frame; snapshot beats live inputs
    task automatic t_chain();
        logic [31:0] rx;
        @(posedge hclk);
        chain_select_strap <= 1'h1;
        frame({1'h0, 7'h33, 8'h00}, 32'h1, rx);
        check(last_rd, 7'h33);
        field_input_states <= 8'h3C;
        repeat (6) @(posedge hclk);
        latch_n <= 1'h0;
        repeat (6) @(posedge hclk);
        latch_n <= 1'h1;
        field_input_states <= 8'hC3;
        repeat (6) @(posedge hclk);
        bus(1'h1, 32'h14, {16'h0, 1'h1, 7'h01, 8'h7E}, rx);
        frame(16'h4C21, 32'h11, rx);
        check(rx[23:16], 8'h3C);
        check(rx[15:8], 8'hB3);
        bus(1'h0, 32'h24, 32'h0, rx);
        check(rx[23:8], 16'h4C21);
        check(last_wr, {7'h01, 8'h7E});
    endtask

    // Main sequence
    initial
    begin
        hresetn = 1'h0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'h0;
        hwdata = 32'h0;
        crc_disable_strap = 1'h0;
        chain_select_strap = 1'h0;
        latch_n = 1'h1;
        field_input_states = 8'h5C;
        fce_en = 1'h1;
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (4) @(posedge hclk);
        t_bad_code();
        t_direct_write();
        t_direct_read();
        t_chain();
        wrap_up();
    end
endmodule
